// *** rtl/mmcc_pkg.sv ***
// Constants, types and helpers for the multi-mode counter channel
package mmcc_pkg;

    // ==========================================================
    // Clocking
    localparam int CLK_MHZ = 250;
    localparam int TB_MHZ = 80;
    localparam logic [7:0] TB_STEP = 8'(TB_MHZ);
    localparam logic [7:0] TB_WRAP = 8'(CLK_MHZ - TB_MHZ);

    // ==========================================================
    // Filter gate times in ns
    localparam int GATE0_NS = 100;
    localparam int GATE1_NS = 200;
    localparam int GATE2_NS = 500;
    localparam int GATE3_NS = 1000;
    localparam int GATE4_NS = 2000;
    localparam int GATE5_NS = 4000;
    localparam int GATE6_NS = 5000;
    localparam logic [2:0] FILT_BYPASS = 3'h0;

    // ==========================================================
    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_COUNT = 8'h08;
    localparam logic [7:0] ADDR_RESULT = 8'h0C;
    localparam logic [7:0] ADDR_SAMPLE = 8'h10;

    // Input line indices within the pin vector
    localparam int IN_A = 0;
    localparam int IN_B = 1;
    localparam int IN_Z = 2;

    typedef enum logic [2:0] {
        MODE_EVENT = 3'h0,
        MODE_PERIOD = 3'h1,
        MODE_WIDTH = 3'h2,
        MODE_SEPARATION = 3'h3,
        MODE_SINGLE_EDGE_QUADRATURE = 3'h4,
        MODE_DOUBLE_EDGE_QUADRATURE = 3'h5,
        MODE_QUAD_EDGE_QUADRATURE = 3'h6,
        MODE_UP_DOWN = 3'h7
    } mmcc_mode_e;

    // Measurement run state, Gray coded idle -> run
    typedef enum logic [1:0] {
        MST_IDLE = 2'h0,
        MST_RUN = 2'h1
    } mmcc_mst_e;

    // Control register layout, MSB first
    typedef struct packed {
        logic [16:0] rsvd;
        logic index_en;
        logic zero_out;
        logic keep_count;
        logic rsvd_f;
        logic [2:0] filter_sel;
        logic rsvd_i;
        logic [2:0] invert;
        logic event_src_b;
        mmcc_mode_e mode;
    } mmcc_ctrl_s;

    localparam mmcc_ctrl_s CTRL_RESET = '0;

    function automatic logic [8:0] ns_to_ticks(input int ns);
        ns_to_ticks = 9'(ns * TB_MHZ / 1000);
    endfunction

    function automatic logic [8:0] gate_ticks(input logic [2:0] sel);
        case (sel)
            3'h1: gate_ticks = ns_to_ticks(GATE0_NS);
            3'h2: gate_ticks = ns_to_ticks(GATE1_NS);
            3'h3: gate_ticks = ns_to_ticks(GATE2_NS);
            3'h4: gate_ticks = ns_to_ticks(GATE3_NS);
            3'h5: gate_ticks = ns_to_ticks(GATE4_NS);
            3'h6: gate_ticks = ns_to_ticks(GATE5_NS);
            3'h7: gate_ticks = ns_to_ticks(GATE6_NS);
            default: gate_ticks = 9'h001;
        endcase
    endfunction

    function automatic logic is_meas(input mmcc_mode_e m);
        is_meas = (m == MODE_PERIOD) || (m == MODE_WIDTH) || (m == MODE_SEPARATION);
    endfunction

endpackage

// *** rtl/mmcc_top.sv ***
// Multi-mode counter channel: input conditioning, counting modes, APB slave
`timescale 1ns/10ps
module mmcc_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [2:0] in_pins,
    input wire logic acq_start,
    input wire logic acq_clock,
    output logic [31:0] sample_value,
    output logic sample_strobe
);

    // ==========================================================
    // Declarations
    mmcc_pkg::mmcc_ctrl_s ctrl;
    mmcc_pkg::mmcc_mst_e mst;
    logic [2:0] sync1, sync2;
    logic [2:0] filt;
    logic [2:0] lvl, lvl_q;
    logic [2:0] rise, fall;
    logic [8:0] fcnt [3];
    logic [8:0] gate;
    logic [7:0] tb_acc;
    logic tb_tick;
    logic [31:0] count, result;
    logic new_flag, set_new;
    logic step_up, step_dn;
    logic index_hit;
    logic wr_en, setup;

    // ==========================================================
    // Time base: 80 MHz tick from the 250 MHz clock by a phase
    // accumulator; ticks jitter by one clock but average exactly.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tb_acc <= 8'h00;
            tb_tick <= 1'b0;
        end
        else if (tb_acc >= mmcc_pkg::TB_WRAP)
        begin
            tb_acc <= tb_acc - mmcc_pkg::TB_WRAP;
            tb_tick <= 1'b1;
        end
        else
        begin
            tb_acc <= tb_acc + mmcc_pkg::TB_STEP;
            tb_tick <= 1'b0;
        end
    end

    // ==========================================================
    // Pin synchroniser and edge-detect history
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1 <= 3'h0;
            sync2 <= 3'h0;
            lvl_q <= 3'h0;
        end
        else
        begin
            sync1 <= in_pins;
            sync2 <= sync1;
            lvl_q <= lvl;
        end
    end

    // ==========================================================
    // Glitch filter
    assign gate = mmcc_pkg::gate_ticks(ctrl.filter_sel);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            filt <= 3'h0;
            for (int i = 0; i < 3; i++)
                fcnt[i] <= 9'h000;
        end
        else if (tb_tick)
        begin
            for (int i = 0; i < 3; i++)
            begin
                if ((sync2[i] ^ ctrl.invert[i]) != filt[i])
                begin
                    // A level must be seen on gate consecutive ticks
                    if (fcnt[i] >= gate - 9'h001)
                    begin
                        filt[i] <= sync2[i] ^ ctrl.invert[i];
                        fcnt[i] <= 9'h000;
                    end
                    else
                    begin
                        fcnt[i] <= fcnt[i] + 9'h001;
                    end
                end
                else
                begin
                    fcnt[i] <= 9'h000;
                end
            end
        end
    end

    // Bypass skips the filter delay but still sees the two sync flops
    assign lvl = (ctrl.filter_sel == mmcc_pkg::FILT_BYPASS) ? (sync2 ^ ctrl.invert)
                                                            : filt;

    assign rise = lvl & ~lvl_q;
    assign fall = ~lvl & lvl_q;

    // ==========================================================
    // Count direction for event, quadrature and up/down modes
    always_comb
    begin
        step_up = 1'b0;
        step_dn = 1'b0;
        case (ctrl.mode)
            mmcc_pkg::MODE_EVENT:
                step_up = ctrl.event_src_b ? rise[mmcc_pkg::IN_B]
                                           : rise[mmcc_pkg::IN_A];
            mmcc_pkg::MODE_SINGLE_EDGE_QUADRATURE:
            begin
                step_up = rise[mmcc_pkg::IN_A] & ~lvl[mmcc_pkg::IN_B];
                step_dn = fall[mmcc_pkg::IN_A] & ~lvl[mmcc_pkg::IN_B];
            end
            mmcc_pkg::MODE_DOUBLE_EDGE_QUADRATURE:
            begin
                step_up = (rise[mmcc_pkg::IN_A] & ~lvl[mmcc_pkg::IN_B])
                        | (fall[mmcc_pkg::IN_A] & lvl[mmcc_pkg::IN_B]);
                step_dn = (rise[mmcc_pkg::IN_A] & lvl[mmcc_pkg::IN_B])
                        | (fall[mmcc_pkg::IN_A] & ~lvl[mmcc_pkg::IN_B]);
            end
            mmcc_pkg::MODE_QUAD_EDGE_QUADRATURE:
            begin
                // Edges on A and B in one cycle only arise from a glitch; B wins
                if (rise[mmcc_pkg::IN_B] | fall[mmcc_pkg::IN_B])
                begin
                    step_up = rise[mmcc_pkg::IN_B] ~^ lvl[mmcc_pkg::IN_A];
                    step_dn = rise[mmcc_pkg::IN_B] ^ lvl[mmcc_pkg::IN_A];
                end
                else if (rise[mmcc_pkg::IN_A] | fall[mmcc_pkg::IN_A])
                begin
                    step_up = rise[mmcc_pkg::IN_A] ^ lvl[mmcc_pkg::IN_B];
                    step_dn = rise[mmcc_pkg::IN_A] ~^ lvl[mmcc_pkg::IN_B];
                end
            end
            mmcc_pkg::MODE_UP_DOWN:
            begin
                // Simultaneous rises cancel out
                step_up = rise[mmcc_pkg::IN_A] & ~rise[mmcc_pkg::IN_B];
                step_dn = rise[mmcc_pkg::IN_B] & ~rise[mmcc_pkg::IN_A];
            end
            default:
                step_up = 1'b0;
        endcase
    end

    // Index reload in the all-high phase, quadrature modes only
    assign index_hit = ctrl.index_en & ctrl.mode[2] & (ctrl.mode != mmcc_pkg::MODE_UP_DOWN)
                     & (&lvl);

    // ==========================================================
    // Counter, result and measurement state
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count <= 32'h0000_0000;
            result <= 32'h0000_0000;
            mst <= mmcc_pkg::MST_IDLE;
            set_new <= 1'b0;
            new_flag <= 1'b0;
        end
        else
        begin
            set_new <= 1'b0;
            // A latch in the sampling cycle survives for the next sample
            new_flag <= set_new | (new_flag & ~acq_clock);
            if (acq_start && !ctrl.keep_count)
            begin
                count <= 32'h0000_0000;
                result <= 32'h0000_0000;
                mst <= mmcc_pkg::MST_IDLE;
            end
            else if (!mmcc_pkg::is_meas(ctrl.mode))
            begin
                if (index_hit)
                    count <= 32'h0000_0000;
                else if (step_up)
                    count <= count + 32'h0000_0001;
                else if (step_dn)
                    count <= count - 32'h0000_0001;
            end
            else
            begin
                case (ctrl.mode)
                    mmcc_pkg::MODE_PERIOD:
                    begin
                        if (rise[mmcc_pkg::IN_A])
                        begin
                            // The first rise only opens a period
                            if (mst == mmcc_pkg::MST_RUN)
                            begin
                                result <= count;
                                set_new <= 1'b1;
                            end
                            // A restart takes the coinciding tick, so k ticks read k
                            count <= {31'h0, tb_tick};
                            mst <= mmcc_pkg::MST_RUN;
                        end
                        else if (tb_tick && mst == mmcc_pkg::MST_RUN)
                            count <= count + 32'h0000_0001;
                    end
                    mmcc_pkg::MODE_WIDTH:
                    begin
                        if (rise[mmcc_pkg::IN_A])
                        begin
                            count <= {31'h0, tb_tick};
                            mst <= mmcc_pkg::MST_RUN;
                        end
                        else if (fall[mmcc_pkg::IN_A] && mst == mmcc_pkg::MST_RUN)
                        begin
                            result <= count;
                            set_new <= 1'b1;
                            count <= 32'h0000_0000;
                            mst <= mmcc_pkg::MST_IDLE;
                        end
                        else if (tb_tick && mst == mmcc_pkg::MST_RUN)
                            count <= count + 32'h0000_0001;
                    end
                    default:
                    begin
                        if (mst == mmcc_pkg::MST_IDLE && rise[mmcc_pkg::IN_A])
                        begin
                            count <= {31'h0, tb_tick};
                            mst <= mmcc_pkg::MST_RUN;
                        end
                        else if (mst == mmcc_pkg::MST_RUN && rise[mmcc_pkg::IN_B])
                        begin
                            result <= count;
                            set_new <= 1'b1;
                            mst <= mmcc_pkg::MST_IDLE;
                        end
                        else if (tb_tick && mst == mmcc_pkg::MST_RUN)
                            count <= count + 32'h0000_0001;
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // Acquisition sample, whole word in one cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sample_value <= 32'h0000_0000;
            sample_strobe <= 1'b0;
        end
        else
        begin
            sample_strobe <= acq_clock;
            if (acq_clock)
            begin
                if (!mmcc_pkg::is_meas(ctrl.mode))
                    sample_value <= count;
                else if (new_flag || set_new || !ctrl.zero_out)
                    sample_value <= result;
                else
                    sample_value <= 32'h0000_0000;
            end
        end
    end

    // ==========================================================
    // APB slave: one wait-free access, data fetched in setup
    assign setup = psel & ~penable;
    assign wr_en = psel & penable & pwrite & pready;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            pready <= setup;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            if (setup)
            begin
                case (paddr)
                    mmcc_pkg::ADDR_CTRL: prdata <= ctrl;
                    mmcc_pkg::ADDR_STATUS: prdata <= {27'h0, mst[0], new_flag, lvl};
                    mmcc_pkg::ADDR_COUNT: prdata <= count;
                    mmcc_pkg::ADDR_RESULT: prdata <= result;
                    mmcc_pkg::ADDR_SAMPLE: prdata <= sample_value;
                    default: pslverr <= 1'b1;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl <= mmcc_pkg::CTRL_RESET;
        end
        else if (wr_en && paddr == mmcc_pkg::ADDR_CTRL)
        begin
            ctrl <= mmcc_pkg::mmcc_ctrl_s'(pwdata);
            ctrl.rsvd <= '0;
            ctrl.rsvd_f <= '0;
            ctrl.rsvd_i <= 1'b0;
        end
    end

endmodule

// *** test/mmcc_chk.sv ***
// Port-level assertions for the multi-mode counter channel
`timescale 1ns/10ps
module mmcc_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic acq_clock,
    input wire logic [31:0] sample_value,
    input wire logic sample_strobe
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // ==========================================================
    // Register bus
    a_ready_setup: assert property (psel && !penable |=> pready)
        else $error("no ready one cycle after setup");
    a_ready_access: assert property (pready |-> psel && penable)
        else $error("ready outside an access phase");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_err_unmapped: assert property (pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 8'h10))
        else $error("error flag does not match address map");
    a_err_nodata: assert property (pslverr |-> prdata == 32'h0 && pready)
        else $error("error response carries data");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside access");

    // ==========================================================
    // Acquisition sampling
    a_strobe_acq: assert property (acq_clock |=> sample_strobe)
        else $error("no sample after acquisition clock");
    a_strobe_cause: assert property (sample_strobe |-> $past(acq_clock))
        else $error("sample without acquisition clock");
    a_sample_hold: assert property ($changed(sample_value) |-> sample_strobe)
        else $error("sample value moved without strobe");

    c_err: cover property (pslverr);
    c_sample: cover property (sample_strobe && sample_value != 32'h0);
    c_write: cover property (psel && penable && pwrite && pready);
endmodule

bind mmcc_top mmcc_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .acq_clock(acq_clock), .sample_value(sample_value), .sample_strobe(sample_strobe));

// *** test/mmcc_enc.sv ***
// Encoder and pulse source model driving the counter input pins
`timescale 1ns/10ps
module mmcc_enc (
    input wire logic clk,
    output logic [2:0] pins
);
    initial pins = 3'h0;

    // Toggling rather than setting lets inverted-idle lines pulse too
    task automatic pulse(input int ln, input int on, input int off);
        pins[ln] <= ~pins[ln];
        repeat (on) @(posedge clk);
        pins[ln] <= ~pins[ln];
        repeat (off) @(posedge clk);
    endtask

    task automatic flip(input int ln);
        pins[ln] <= ~pins[ln];
        repeat (4) @(posedge clk);
    endtask

    // Full quadrature cycles, index only while both phases are high
    task automatic quad(input logic fwd, input int n, input logic idx);
        logic a;
        logic b;
        for (int i = 0; i < n; i++)
            for (int s = 0; s < 4; s++)
            begin
                a = (s < 2);
                b = (s == 1 || s == 2);
                pins <= fwd ? {idx && i == 0 && s == 1, b, a} : {1'b0, a, b};
                repeat (4) @(posedge clk);
            end
    endtask
endmodule

// *** test/tb_top.sv ***
// Self-checking testbench for the multi-mode counter channel
`timescale 1ns/10ps
module tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic acq_start, acq_clock, sample_strobe;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, sample_value, r;
    logic [2:0] pins;
    logic [32:0] rq[$];
    logic [31:0] sq[$];
    int fails = 0;
    int checked = 0;
    int seed = 78;
    int n, m, w;
    int gns[8] = '{0, 100, 200, 500, 1000, 2000, 4000, 5000};
    mmcc_pkg::mmcc_ctrl_s c;

    mmcc_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .in_pins(pins), .acq_start(acq_start), .acq_clock(acq_clock),
        .sample_value(sample_value), .sample_strobe(sample_strobe));
    mmcc_enc enc_u (.clk(pclk), .pins(pins));

    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // ==========================================================
    // Checking
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic stop_test;
        $display("checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    always @(posedge pclk)
    begin
        if (pready === 1'b1 && pwrite === 1'b0)
            check({pslverr, prdata}, rq.size() ? rq.pop_front() : 'x);
        if (sample_strobe === 1'b1)
            check({1'b0, sample_value}, sq.size() ? {1'b0, sq.pop_front()} : 'x);
    end

    // ==========================================================
    // Drivers
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the answer
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        rq.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask

    task automatic set_mode(input mmcc_pkg::mmcc_mode_e md);
        c.mode = md;
        apb(1'b1, mmcc_pkg::ADDR_CTRL, c);
        repeat (8) @(posedge pclk);
        acq_start <= 1'b1;
        @(posedge pclk);
        acq_start <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic acq(input logic [31:0] e);
        repeat (12) @(posedge pclk);
        sq.push_back(e);
        acq_clock <= 1'b1;
        @(posedge pclk);
        acq_clock <= 1'b0;
        repeat (2) @(posedge pclk);
        rd(mmcc_pkg::ADDR_SAMPLE, {1'b0, e});
    endtask

    initial
    begin
        repeat (60000) @(posedge pclk);
        fails++;
        stop_test();
    end

    // ==========================================================
    // Scenarios
    initial
    begin
        {presetn, psel, penable, pwrite, acq_start, acq_clock} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        c = mmcc_pkg::CTRL_RESET;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(mmcc_pkg::ADDR_CTRL, 33'h0);
        r = $random(seed);
        apb(1'b1, mmcc_pkg::ADDR_CTRL, r);
        apb(1'b1, 8'h14, ~r);
        rd(8'h14, 33'h1_0000_0000);
        rd(mmcc_pkg::ADDR_CTRL, {1'b0, r & 32'h0000_777F});
        // Source select, inversion and count keeping
        for (int i = 0; i < 4; i++)
        begin
            c = '0;
            c.invert[i / 2] = i[0];
            c.event_src_b = i[1];
            set_mode(mmcc_pkg::MODE_EVENT);
            n = 1 + {$random(seed)} % 7;
            enc_u.pulse(1 - i / 2, 3, 3);
            repeat (n) enc_u.pulse(i / 2, 3, 3);
            enc_u.flip(i / 2);
            acq(32'(n + !i[0]));
            enc_u.flip(i / 2);
            c.keep_count = i[0];
            set_mode(mmcc_pkg::MODE_EVENT);
            repeat (n) enc_u.pulse(i / 2, 3, 3);
            acq(32'((i[0] ? n + 1 : 0) + n));
        end
        // Every gate time: a gate-long pulse passes, a 28 ns shorter one is lost
        for (int f = 0; f < 8; f++)
        begin
            c = '0;
            c.filter_sel = 3'(f);
            set_mode(mmcc_pkg::MODE_EVENT);
            w = f ? gns[f] / 4 : 2;
            enc_u.pulse(0, w, w);
            if (f > 0)
                enc_u.pulse(0, (gns[f] - 25) / 4, w);
            acq(32'h1);
        end
        // Measurement spans are multiples of 25 cycles, exactly 8 ticks each
        for (int z = 0; z < 2; z++)
        begin
            c = '0;
            c.zero_out = z[0];
            set_mode(mmcc_pkg::MODE_PERIOD);
            repeat (3) enc_u.pulse(0, 25, 25);
            acq(32'd16);
            rd(mmcc_pkg::ADDR_STATUS, 33'h0_0000_0010);
            acq(z ? 32'd0 : 32'd16);
        end
        set_mode(mmcc_pkg::MODE_WIDTH);
        enc_u.pulse(0, 75, 10);
        acq(32'd24);
        enc_u.pulse(0, 50, 10);
        acq(32'd16);
        rd(mmcc_pkg::ADDR_RESULT, {1'b0, 32'd16});
        set_mode(mmcc_pkg::MODE_SEPARATION);
        enc_u.pulse(0, 10, 30);
        enc_u.pulse(0, 10, 50);
        enc_u.pulse(1, 10, 10);
        acq(32'd32);
        for (int q = 0; q < 3; q++)
        begin
            set_mode(mmcc_pkg::mmcc_mode_e'(3'(4 + q)));
            n = 2 + {$random(seed)} % 6;
            m = 1 + {$random(seed)} % (n - 1);
            enc_u.quad(1'b1, n, 1'b0);
            enc_u.quad(1'b0, m, 1'b0);
            acq(32'((n - m) << q));
        end
        for (int x = 0; x < 2; x++)
        begin
            c.index_en = x[0];
            set_mode(mmcc_pkg::MODE_SINGLE_EDGE_QUADRATURE);
            enc_u.quad(1'b1, n, 1'b1);
            enc_u.pulse(2, 3, 3);
            acq(32'(n - x));
        end
        set_mode(mmcc_pkg::MODE_UP_DOWN);
        repeat (n) enc_u.pulse(0, 3, 3);
        repeat (2) enc_u.pulse(1, 3, 3);
        acq(32'(n - 2));
        rd(mmcc_pkg::ADDR_COUNT, {1'b0, 32'(n - 2)});
        repeat (4) @(posedge pclk);
        fails += rq.size() + sq.size();
        stop_test();
    end
endmodule
